// *** design/usac_core.sv ***
// serial transceiver core with register port, clocking and line logic
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module usac_core
    import usac_pkg::*;
#(
    parameter int BRG_W = 16
) (
    input wire logic core_clk, // 100 MHz clock
    input wire logic rst, // synchronous reset, high
    input wire logic [7:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    input wire logic serial_in, // receive line
    output logic serial_out, // transmit line
    output logic request_to_send_n, // low: receiver can accept
    input wire logic clear_to_send_n, // low: far end can accept
    input wire logic serial_clock_pin_in, // serial clock pin level
    output logic serial_clock_pin_out, // serial clock driven level
    output logic serial_clock_pin_oe_n, // low while driving clock
    output logic wake_request // raised and enabled event
);
    initial begin
        if (BRG_W < 1 || BRG_W > 16) begin
            $error("usac_core: BRG_W out of range");
        end
    end

    function automatic logic [3:0] data_bits(input logic [1:0] len);
        return (len == LEN_7) ? 4'h7 : (len == LEN_8) ? 4'h8 : 4'h9;
    endfunction

    logic [CFG_W-1:0] cfg;
    logic [CTRL_W-1:0] ctrl;
    logic [ST_W-1:0] flags, inten, stat_vec, set_vec;
    logic [BRG_W-1:0] baud_divider_value, brg_cnt, brg_lim;
    logic [7:0] main_clock_divider, fraction_multiplier, fraction_divider_reg;
    logic [7:0] div_cnt, frac_acc;
    logic frac_owe, div_tick, pclk_tick, baud_tick;
    logic [1:0] rxd_s, cts_s, sck_s;
    logic line_in, cts_in, sclk_view, sclk_prev, sample_edge, shift_edge;
    logic en, sync, master, par_on;
    logic [3:0] nb;
    assign en = cfg[CFG_EN];
    assign sync = cfg[CFG_SYNC];
    assign master = cfg[CFG_MASTER];
    assign par_on = cfg[CFG_PAR+1];
    assign nb = data_bits(cfg[CFG_LEN+:2]);

    // pin synchronisers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rxd_s <= 2'h3;
            cts_s <= 2'h3;
            sck_s <= 2'h0;
        end else begin
            rxd_s <= {rxd_s[0], serial_in};
            cts_s <= {cts_s[0], clear_to_send_n};
            sck_s <= {sck_s[0], serial_clock_pin_in};
        end
    end
    assign line_in = cfg[CFG_LOOP] ? serial_out : rxd_s[1];
    assign cts_in = cfg[CFG_LOOP] ? request_to_send_n : cts_s[1];
    // slave uses the pin clock, master its own generated clock
    assign sclk_view = master ? serial_clock_pin_out : sck_s[1];

    // fractional generator: m of every 256+m divided ticks are swallowed
    assign div_tick = (main_clock_divider != 8'h00)
        && (div_cnt >= main_clock_divider - 8'h01);
    assign pclk_tick = div_tick && !frac_owe;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_cnt <= 8'h00;
            frac_acc <= 8'h00;
            frac_owe <= 1'b0;
        end else begin
            div_cnt <= div_tick ? 8'h00 : div_cnt + 8'h01;
            if (div_tick && frac_owe) begin
                frac_owe <= 1'b0;
            end else if (div_tick) begin
                {frac_owe, frac_acc} <= {1'b0, frac_acc}
                    + {1'b0, fraction_multiplier};
            end
        end
    end

    // baud divider
    assign brg_lim = (baud_divider_value == '0) ? BRG_W'(1)
        : baud_divider_value;
    assign baud_tick = pclk_tick && (brg_cnt >= brg_lim - BRG_W'(1));
    always_ff @(posedge core_clk) begin
        if (rst) begin
            brg_cnt <= '0;
        end else if (baud_tick) begin
            brg_cnt <= '0;
        end else if (pclk_tick) begin
            brg_cnt <= brg_cnt + BRG_W'(1);
        end
    end

    // transmitter
    usac_tx_t tx_state;
    logic [8:0] tx_buf;
    logic tx_full, tx_load, tx_bit_tick, tx_start_ok;
    logic [12:0] tx_shift;
    logic [3:0] tx_cnt, tx_os;
    logic [12:0] next_frame;
    logic next_par;
    always_comb begin
        next_frame = 13'h1FFE;
        next_par = cfg[CFG_PAR];
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < nb) begin
                next_frame[i+1] = tx_buf[i];
                next_par = next_par ^ tx_buf[i];
            end
        end
        if (par_on) begin
            next_frame[nb+4'h1] = next_par;
        end
    end
    assign tx_start_ok = en && tx_full && tx_state == TX_IDLE
        && !ctrl[CTRL_TXDIS]
        && !(cfg[CFG_FLOW] && cts_in);
    // async start waits for the bit counter wrap so the start bit is whole
    assign tx_load = tx_start_ok && (sync || tx_bit_tick);
    assign tx_bit_tick = sync ? shift_edge
        : (baud_tick && tx_os == OS_LAST);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_os <= 4'h0;
        end else if (baud_tick) begin
            tx_os <= tx_os + 4'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_state <= TX_IDLE;
            tx_shift <= 13'h1FFF;
            tx_cnt <= 4'h0;
        end else if (tx_load) begin
            tx_state <= TX_SHIFT;
            tx_shift <= next_frame;
            tx_cnt <= nb + 4'(par_on) + 4'(cfg[CFG_STOP2]) + 4'h2;
        end else if (tx_state == TX_SHIFT && tx_bit_tick) begin
            tx_shift <= {1'b1, tx_shift[12:1]};
            tx_cnt <= tx_cnt - 4'h1;
            if (tx_cnt == 4'h1) begin
                tx_state <= TX_IDLE;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_full <= 1'b0;
            tx_buf <= 9'h000;
        end else if (reg_wr && reg_addr == OFS_TRANSMIT_BUFFER) begin
            tx_full <= 1'b1;
            tx_buf <= reg_wdata[8:0];
        end else if (tx_load) begin
            tx_full <= 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            serial_out <= 1'b1;
        end else begin
            serial_out <= !ctrl[CTRL_TXBRK] && tx_shift[0];
        end
    end

    // master clock: idle level first half, sample edge, shift edge at wrap
    always_ff @(posedge core_clk) begin
        if (rst) begin
            serial_clock_pin_out <= 1'b0;
            serial_clock_pin_oe_n <= 1'b1;
            sclk_prev <= 1'b0;
        end else begin
            serial_clock_pin_oe_n <= !(sync && master);
            if (sync && master && (tx_state == TX_SHIFT
                    || ctrl[CTRL_CONTCLK])) begin
                serial_clock_pin_out <= (brg_cnt < (brg_lim >> 1))
                    ? !cfg[CFG_CLKPOL] : cfg[CFG_CLKPOL];
            end else begin
                serial_clock_pin_out <= !cfg[CFG_CLKPOL];
            end
            sclk_prev <= sclk_view;
        end
    end
    assign sample_edge = sync && (sclk_view != sclk_prev)
        && (sclk_view == cfg[CFG_CLKPOL]);
    assign shift_edge = sync && (sclk_view != sclk_prev)
        && (sclk_view != cfg[CFG_CLKPOL]);

    // receiver
    usac_rx_t rx_state;
    logic [3:0] rx_os, rx_idx;
    logic [2:0] votes;
    logic [8:0] rx_data, rx_buf;
    logic rx_par, rx_prev, rx_full, rx_take, rx_done, rx_start;
    logic bit_evt, bit_val, noisy, rx_brk, frame_bad, par_bad, is_brk;
    logic par_exp;
    assign bit_evt = rx_state == RX_FRAME && (sync ? sample_edge
        : (baud_tick && rx_os == VOTE_C));
    assign bit_val = sync ? line_in
        : (votes[0] & votes[1]) | (votes[0] & line_in)
        | (votes[1] & line_in);
    assign noisy = !sync && bit_evt
        && !(votes[0] == votes[1] && votes[1] == line_in);
    assign rx_start = rx_state == RX_IDLE && en && (sync
        ? (sample_edge && !line_in)
        : (baud_tick && rx_prev && !line_in));
    assign par_exp = cfg[CFG_PAR] ^ (^rx_data);
    assign rx_done = bit_evt && rx_idx == nb + 4'(par_on) + 4'h1;
    assign frame_bad = rx_done && !bit_val;
    assign par_bad = rx_done && par_on && rx_par != par_exp;
    assign is_brk = frame_bad && rx_data == 9'h000
        && !(par_on && rx_par);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_state <= RX_IDLE;
            rx_os <= 4'h0;
            rx_idx <= 4'h0;
            rx_prev <= 1'b1;
            votes <= 3'h7;
            rx_data <= 9'h000;
            rx_par <= 1'b0;
        end else begin
            if (baud_tick) begin
                rx_prev <= line_in;
                rx_os <= rx_os + 4'h1;
            end
            if (baud_tick && rx_os >= VOTE_A && rx_os < VOTE_C) begin
                votes <= {votes[1:0], line_in};
            end
            unique case (rx_state)
                RX_IDLE: begin
                    if (rx_start) begin
                        rx_state <= RX_FRAME;
                        rx_os <= 4'h1;
                        rx_data <= 9'h000;
                        rx_idx <= sync ? 4'h1 : 4'h0;
                    end
                end
                RX_FRAME: begin
                    if (bit_evt) begin
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx == 4'h0 && bit_val) begin
                            rx_state <= RX_IDLE;
                        end else if (rx_idx != 4'h0 && rx_idx <= nb) begin
                            rx_data[rx_idx-4'h1] <= bit_val;
                        end else if (rx_idx == nb + 4'h1 && par_on) begin
                            rx_par <= bit_val;
                        end
                        if (rx_done) begin
                            rx_state <= RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end
    // ninth bit kept as received; address compare is left to software
    assign rx_take = reg_rd && (reg_addr == OFS_RECEIVE_BUFFER
        || reg_addr == OFS_RXDATASTAT);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_full <= 1'b0;
            rx_buf <= 9'h000;
        end else begin
            rx_full <= rx_done || (rx_full && !rx_take);
            if (rx_done) begin
                rx_buf <= rx_data;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_brk <= 1'b0;
        end else if (is_brk) begin
            rx_brk <= 1'b1;
        end else if (rx_state == RX_IDLE && line_in) begin
            rx_brk <= 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            request_to_send_n <= 1'b1;
        end else begin
            request_to_send_n <= rx_full || !en;
        end
    end

    // status and events
    logic cts_prev, brk_prev;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cts_prev <= 1'b1;
            brk_prev <= 1'b0;
        end else begin
            cts_prev <= cts_in;
            brk_prev <= rx_brk;
        end
    end
    always_comb begin
        set_vec = '0;
        set_vec[ST_DCTS] = cts_in != cts_prev;
        set_vec[ST_OVR] = rx_done && rx_full && !rx_take;
        set_vec[ST_DRXBRK] = rx_brk != brk_prev;
        set_vec[ST_START] = rx_start;
        set_vec[ST_FRAME] = frame_bad;
        set_vec[ST_PARITY] = par_bad;
        set_vec[ST_NOISE] = noisy;
        set_vec[ST_UNDER] = en && sync && !master && shift_edge
            && tx_state == TX_IDLE && !tx_full;
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flags <= '0;
        end else if (reg_wr && reg_addr == OFS_STAT) begin
            // set wins over a same-cycle clear
            flags <= set_vec | (flags & ~reg_wdata[ST_W-1:0]);
        end else begin
            flags <= set_vec | flags;
        end
    end
    always_comb begin
        stat_vec = flags & ST_STICKY;
        stat_vec[ST_RXRDY] = rx_full;
        stat_vec[ST_RXIDLE] = rx_state == RX_IDLE;
        stat_vec[ST_TXRDY] = !tx_full;
        stat_vec[ST_TXIDLE] = tx_state == TX_IDLE;
        stat_vec[ST_CTS] = cts_in;
        stat_vec[ST_TXDIS] = ctrl[CTRL_TXDIS] && tx_state == TX_IDLE;
        stat_vec[ST_RXBRK] = rx_brk;
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= |(stat_vec & inten);
        end
    end

    // register writes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg <= '0;
            ctrl <= '0;
            inten <= '0;
            baud_divider_value <= '0;
            main_clock_divider <= 8'h00;
            fraction_multiplier <= 8'h00;
            fraction_divider_reg <= FRGDIV_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                OFS_CFG: cfg <= reg_wdata[CFG_W-1:0];
                OFS_CTRL: ctrl <= reg_wdata[CTRL_W-1:0];
                OFS_IRQ_ENABLE_SET: inten <= inten | reg_wdata[ST_W-1:0];
                OFS_INTENCLR: inten <= inten & ~reg_wdata[ST_W-1:0];
                OFS_BRG: baud_divider_value <= reg_wdata[BRG_W-1:0];
                OFS_CLKDIV: main_clock_divider <= reg_wdata[7:0];
                OFS_FRGMULT: fraction_multiplier <= reg_wdata[7:0];
                OFS_FRGDIV: fraction_divider_reg <= reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    // register reads, answered in the following cycle
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (reg_addr)
            OFS_CFG: next_rdata[CFG_W-1:0] = cfg;
            OFS_CTRL: next_rdata[CTRL_W-1:0] = ctrl;
            OFS_STAT: next_rdata[ST_W-1:0] = stat_vec;
            OFS_IRQ_ENABLE_SET: next_rdata[ST_W-1:0] = inten;
            OFS_RECEIVE_BUFFER: next_rdata[8:0] = rx_buf;
            OFS_RXDATASTAT: begin
                next_rdata[8:0] = rx_buf;
                next_rdata[ST_FRAME] = flags[ST_FRAME];
                next_rdata[ST_PARITY] = flags[ST_PARITY];
                next_rdata[ST_NOISE] = flags[ST_NOISE];
            end
            OFS_TRANSMIT_BUFFER: next_rdata[8:0] = tx_buf;
            OFS_BRG: next_rdata[BRG_W-1:0] = baud_divider_value;
            OFS_INTSTAT: next_rdata[ST_W-1:0] = stat_vec & inten;
            OFS_CLKDIV: next_rdata[7:0] = main_clock_divider;
            OFS_FRGMULT: next_rdata[7:0] = fraction_multiplier;
            OFS_FRGDIV: next_rdata[7:0] = fraction_divider_reg;
            default: next_rdata = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence tx_go_s;
        tx_load ##1 (tx_state == TX_SHIFT);
    endsequence
    sequence rx_fill_s;
        rx_done ##1 rx_full;
    endsequence
    rts_level_a: assert property (rx_full |=> request_to_send_n)
        else $error("request output low with full receive buffer");
    rts_free_a: assert property (en && !rx_full && !rx_done
        |=> !request_to_send_n)
        else $error("request output high while buffer free");
    cts_hold_a: assert property (cfg[CFG_FLOW] && cts_in
        && tx_state == TX_IDLE |=> tx_state == TX_IDLE)
        else $error("transmit started while clear input high");
    tx_load_a: assert property (tx_start_ok && (sync || tx_bit_tick)
        && !reg_wr |-> tx_go_s ##0 !tx_full)
        else $error("held character not moved to shifter");
    rx_buffer_a: assert property (rx_done |-> rx_fill_s
        ##0 rx_buf == $past(rx_data))
        else $error("received character not buffered");
    overrun_set_a: assert property (rx_done && rx_full && !rx_take
        |=> flags[ST_OVR])
        else $error("overrun not flagged");
    frame_err_a: assert property (rx_done && !bit_val
        |=> flags[ST_FRAME])
        else $error("framing error not flagged");
    noise_flag_a: assert property (noisy |=> flags[ST_NOISE])
        else $error("noise not flagged");
    break_line_a: assert property (ctrl[CTRL_TXBRK] |=> !serial_out)
        else $error("break not driven");
    wake_out_a: assert property (|(stat_vec & inten)
        |=> wake_request)
        else $error("enabled event did not request wake");
    rx_read_a: assert property (reg_rd && reg_addr == OFS_RXDATASTAT
        |=> reg_rdata[8:0] == $past(rx_buf))
        else $error("receive data read wrong");
endmodule // usac_core

// *** design/usac_pkg.sv ***
// constants, field layout and types of the serial transceiver core
package usac_pkg;
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h0C;
    localparam logic [7:0] OFS_INTENCLR = 8'h10;
    localparam logic [7:0] OFS_RECEIVE_BUFFER = 8'h14;
    localparam logic [7:0] OFS_RXDATASTAT = 8'h18;
    localparam logic [7:0] OFS_TRANSMIT_BUFFER = 8'h1C;
    localparam logic [7:0] OFS_BRG = 8'h20;
    localparam logic [7:0] OFS_INTSTAT = 8'h24;
    localparam logic [7:0] OFS_CLKDIV = 8'h28;
    localparam logic [7:0] OFS_FRGMULT = 8'h2C;
    localparam logic [7:0] OFS_FRGDIV = 8'h30;
    // configuration fields
    localparam int CFG_EN = 0;
    localparam int CFG_LEN = 2;
    localparam int CFG_PAR = 4;
    localparam int CFG_STOP2 = 6;
    localparam int CFG_FLOW = 9;
    localparam int CFG_SYNC = 11;
    localparam int CFG_CLKPOL = 12;
    localparam int CFG_MASTER = 14;
    localparam int CFG_LOOP = 15;
    localparam int CFG_W = 16;
    // control fields
    localparam int CTRL_TXBRK = 1;
    localparam int CTRL_TXDIS = 6;
    localparam int CTRL_CONTCLK = 9;
    localparam int CTRL_W = 10;
    // status fields
    localparam int ST_RXRDY = 0;
    localparam int ST_RXIDLE = 1;
    localparam int ST_TXRDY = 2;
    localparam int ST_TXIDLE = 3;
    localparam int ST_CTS = 4;
    localparam int ST_DCTS = 5;
    localparam int ST_TXDIS = 6;
    localparam int ST_OVR = 8;
    localparam int ST_RXBRK = 10;
    localparam int ST_DRXBRK = 11;
    localparam int ST_START = 12;
    localparam int ST_FRAME = 13;
    localparam int ST_PARITY = 14;
    localparam int ST_NOISE = 15;
    localparam int ST_UNDER = 16;
    localparam int ST_W = 17;
    // sticky flags, cleared by writing one
    localparam logic [ST_W-1:0] ST_STICKY = 17'h1F920;
    localparam logic [1:0] LEN_7 = 2'h0;
    localparam logic [1:0] LEN_8 = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [7:0] FRGDIV_RST = 8'hFF;
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] VOTE_A = 4'h7;
    localparam logic [3:0] VOTE_C = 4'h9;
    typedef enum logic {TX_IDLE, TX_SHIFT} usac_tx_t;
    typedef enum logic {RX_IDLE, RX_FRAME} usac_rx_t;
endpackage

// *** testbench/usac_core_tb.sv ***
// bench for the serial transceiver core: register tasks and line scenarios
`timescale 1ns/1ps
module usac_core_tb;
    import usac_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic serial_in;
    logic serial_out;
    logic request_to_send_n;
    logic clear_to_send_n;
    logic clk_out;
    logic clk_oe_n;
    logic wake;
    logic [7:0] ch;
    logic [31:0] rd;
    int lows = 0;
    int num_errors = 0;
    int compares = 0;
    always #5 core_clk = ~core_clk;
    usac_core usac_core_i (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in(serial_in),
        .serial_out(serial_out), .request_to_send_n(request_to_send_n),
        .clear_to_send_n(clear_to_send_n), .serial_clock_pin_in(1'b0),
        .serial_clock_pin_out(clk_out), .serial_clock_pin_oe_n(clk_oe_n),
        .wake_request(wake));
    usac_remote usac_remote_i (.core_clk(core_clk), .serial_out(serial_out),
        .serial_in(serial_in), .clear_to_send_n(clear_to_send_n));
    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task automatic get(output logic [7:0] d);
        usac_remote_i.recv(d);
        if (usac_remote_i.timed_out) begin
            num_errors++;
            finish_test();
        end
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd_reg(OFS_STAT, rd);
        chk("stat", 32'h0000000E, rd & 32'hFFFFFFEF);
        chk("rts off", 32'h1, request_to_send_n);
        wr_reg(OFS_CLKDIV, 32'h1);
        wr_reg(OFS_FRGMULT, 32'h0);
        wr_reg(OFS_BRG, 32'h1);
        wr_reg(OFS_CFG, 32'h00000205);
        wr_reg(OFS_TRANSMIT_BUFFER, 32'hA5);
        get(ch);
        chk("tx char", 32'hA5, ch);
        chk("rts ready", 32'h0, request_to_send_n);
        usac_remote_i.send(8'h3C, 1'b1);
        chk("rts full", 32'h1, request_to_send_n);
        rd_reg(OFS_RECEIVE_BUFFER, rd);
        chk("rx char", 32'h3C, rd);
        repeat (4) @(posedge core_clk);
        chk("rts empty", 32'h0, request_to_send_n);
        usac_remote_i.send(8'h81, 1'b1);
        usac_remote_i.send(8'h42, 1'b1);
        rd_reg(OFS_STAT, rd);
        chk("overrun", 32'h1, rd[ST_OVR]);
        rd_reg(OFS_RECEIVE_BUFFER, rd);
        wr_reg(OFS_STAT, 32'(ST_STICKY));
        usac_remote_i.send(8'h55, 1'b0);
        rd_reg(OFS_RXDATASTAT, rd);
        chk("rx stat", 32'h00002055, rd);
        usac_remote_i.hold(1'b1);
        repeat (4) @(posedge core_clk);
        wr_reg(OFS_TRANSMIT_BUFFER, 32'h5A);
        for (int i = 0; i < 64; i++) begin
            @(posedge core_clk);
            lows += (serial_out !== 1'b1);
        end
        chk("held", 32'h0, lows);
        usac_remote_i.hold(1'b0);
        get(ch);
        chk("cts char", 32'h5A, ch);
        wr_reg(OFS_CTRL, 32'h2);
        repeat (2) @(posedge core_clk);
        chk("tx break", 32'h0, serial_out);
        wr_reg(OFS_CTRL, 32'h0);
        wr_reg(OFS_IRQ_ENABLE_SET, 32'h1);
        usac_remote_i.send(8'h00, 1'b0);
        chk("wake", 32'h1, wake);
        rd_reg(OFS_STAT, rd);
        chk("rx break", 32'h1, rd[ST_DRXBRK]);
        rd_reg(OFS_RECEIVE_BUFFER, rd);
        repeat (2) @(posedge core_clk);
        chk("wake off", 32'h0, wake);
        wr_reg(OFS_STAT, 32'(ST_STICKY));
        wr_reg(OFS_CFG, 32'h00000225);
        usac_remote_i.send(8'h01, 1'b0);
        rd_reg(OFS_RXDATASTAT, rd);
        chk("parity", 32'h00004001, rd);
        wr_reg(OFS_CFG, 32'h00008205);
        wr_reg(OFS_TRANSMIT_BUFFER, 32'h69);
        repeat (200) @(posedge core_clk);
        rd_reg(OFS_RECEIVE_BUFFER, rd);
        chk("loop char", 32'h69, rd);
        chk("clk idle", 32'h1, clk_oe_n);
        wr_reg(OFS_BRG, 32'h2);
        wr_reg(OFS_CFG, 32'h00004801);
        wr_reg(OFS_CTRL, 32'h200);
        repeat (2) @(posedge core_clk);
        chk("clk drive", 32'h0, clk_oe_n);
        lows = 0;
        for (int i = 0; i < 32; i++) begin
            @(posedge core_clk);
            lows += (clk_out === 1'b0);
        end
        chk("clk lows", 32'h10, lows);
        rd_reg(8'hFC, rd);
        chk("unmapped", 32'h0, rd);
        finish_test();
    end
endmodule // usac_core_tb

// *** testbench/usac_remote.sv ***
// line side remote device: sends and receives asynchronous characters
`timescale 1ns/1ps
module usac_remote #(
    parameter int BIT = 16
) (
    input wire logic core_clk, // bench clock
    input wire logic serial_out, // line from core
    output logic serial_in, // line to core
    output logic clear_to_send_n // low: remote accepts data
);
    logic timed_out;
    initial begin
        serial_in = 1'b1;
        clear_to_send_n = 1'b0;
        timed_out = 1'b0;
    end
    task automatic hold(input logic v);
        @(posedge core_clk);
        clear_to_send_n <= v;
    endtask
    // start, eight data bits lsb first, then a chosen stop level
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk);
            serial_in <= f[i];
            repeat (BIT - 1) @(posedge core_clk);
        end
        @(posedge core_clk);
        serial_in <= 1'b1;
        repeat (BIT) @(posedge core_clk);
    endtask
    // samples each of the eight data bits in its middle
    task automatic recv(output logic [7:0] d);
        int n;
        d = 8'h00;
        for (n = 0; n < 4000 && serial_out === 1'b1; n++) begin
            @(posedge core_clk);
        end
        timed_out = (n == 4000);
        repeat (BIT / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge core_clk);
            d[i] = serial_out;
        end
    endtask
endmodule // usac_remote
